// ===== include/serial_port_cfg.svh
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

`define SP_ADDR_FAULT_SUMMARY 7'h01
`define SP_ADDR_OC_FAULTS 7'h02
`define SP_ADDR_NOC_FAULTS 7'h03
`define SP_ADDR_OP_STATUS 7'h04
`define SP_ADDR_PIN_CFG_A 7'h05
`define SP_ADDR_PIN_CFG_B 7'h06
`define SP_ADDR_CHIP_CONTROL 7'h07
`define SP_ADDR_LOW_TRIM 7'h08
`define SP_ADDR_HIGH_TRIM 7'h09
`define SP_ADDR_CUR_TRIM 7'h0A
`define SP_ADDR_SSFM 7'h0B

`define SP_RW_RESET 8'h00
`define SP_CRC_SEED 8'h41

`define SP_CTRL_COMM_FAULT_BIT 3
`define SP_CTRL_STICKY_BIT 1
`define SP_CTRL_WPROT_BIT 0

`define SP_CYC_CMD_END 6'd8
`define SP_CYC_CRC_LATCH 6'd16
`define SP_CYC_COMMIT 6'd24

`endif

// ===== include/serial_port_pkg.sv
package serial_port_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_IGNORE = 2'b10
    } burst_state_t;
endpackage

// ===== hdl/crc_checked_serial_register_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_cfg.svh"

module crc_checked_serial_register_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic serial_clock,
    input wire logic serial_input,
    output logic serial_output,
    output logic serial_output_en,
    input wire logic low_side_overvoltage,
    input wire logic high_side_overvoltage,
    input wire logic high_side_undervoltage,
    input wire logic driver_supply_undervoltage,
    input wire logic logic_supply_undervoltage,
    input wire logic reference_bad,
    input wire logic over_temperature,
    input wire logic [5:0] overcurrent_flags,
    input wire logic [5:0] negative_overcurrent_flags,
    input wire logic soft_start_done,
    input wire logic max_current_reached,
    input wire logic regulation_ok,
    input wire logic [7:0] pin_config_a_in,
    input wire logic [7:0] pin_config_b_in,
    output logic [7:0] chip_control,
    output logic [7:0] low_side_voltage_trim,
    output logic [7:0] high_side_voltage_trim,
    output logic [7:0] current_set_trim,
    output logic [7:0] spread_spectrum_cfg
);

    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
        logic crc_term0;
        logic crc_term1;
        logic crc_term2;
        crc_term0 = din ^ crc[7];
        crc_term1 = crc[0] ^ crc_term0;
        crc_term2 = crc[1] ^ crc_term0;
        crc_step = {crc[6:2], crc_term2, crc_term1, crc_term0};
    endfunction

    // last falling edge of a write burst, where the check byte verdict is acted on
    function automatic logic write_end(input logic fall, input logic [5:0] cnt, input logic rd);
        write_end = fall && cnt == `SP_CYC_COMMIT && !rd;
    endfunction

    // pins are asynchronous to sys_clk: two flops before use
    // edges show about three cycles late, so a serial clock period needs eight sys_clk cycles
    logic [1:0] sel_sync_q;
    logic [1:0] clk_sync_q;
    logic [1:0] din_sync_q;
    logic clk_prev_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_sync_q <= 2'h3;
            clk_sync_q <= 2'h0;
            din_sync_q <= 2'h0;
            // idle level of the serial clock is low, so no false edge follows reset
            clk_prev_q <= 1'b0;
        end else begin
            sel_sync_q <= {sel_sync_q[0], port_select_n};
            clk_sync_q <= {clk_sync_q[0], serial_clock};
            din_sync_q <= {din_sync_q[0], serial_input};
            clk_prev_q <= clk_sync_q[1];
        end
    end

    logic sel_n;
    logic sclk_rise;
    logic sclk_fall;
    assign sel_n = sel_sync_q[1];
    assign sclk_rise = clk_sync_q[1] & ~clk_prev_q;
    assign sclk_fall = ~clk_sync_q[1] & clk_prev_q;

    serial_port_pkg::burst_state_t state_q;
    logic [5:0] bit_cnt_q;
    logic [7:0] shift_in_q;
    logic [7:0] cmd_q;
    logic [7:0] data_q;
    logic [7:0] crc_q;
    logic [7:0] crc_hold_q;
    logic [7:0] tx_q;
    logic crc_ok_q;
    logic out_en_q;
    logic commit_pulse;
    logic comm_fault_set;

    logic is_read;
    logic [6:0] addr;
    assign is_read = cmd_q[0];
    assign addr = cmd_q[7:1];

    // byte completed by the current rising edge, msb first
    logic [7:0] rx_byte;
    assign rx_byte = {shift_in_q[6:0], din_sync_q[1]};

    // reserved bits read as zero
    logic [7:0] fault_bits;
    logic [7:0] status_bits;
    assign fault_bits[7] = 1'b0;
    assign fault_bits[6] = low_side_overvoltage;
    assign fault_bits[5] = high_side_overvoltage;
    assign fault_bits[4] = high_side_undervoltage;
    assign fault_bits[3] = driver_supply_undervoltage;
    assign fault_bits[2] = logic_supply_undervoltage;
    assign fault_bits[1] = reference_bad;
    assign fault_bits[0] = over_temperature;
    assign status_bits[7:3] = 5'h00;
    assign status_bits[2] = soft_start_done;
    assign status_bits[1] = max_current_reached;
    assign status_bits[0] = regulation_ok;

    // levels are taken live when the data byte is loaded, not frozen at select
    logic [7:0] read_mux;
    always_comb begin
        case (addr)
            `SP_ADDR_FAULT_SUMMARY: read_mux = fault_bits;
            `SP_ADDR_OC_FAULTS: read_mux = {2'h0, overcurrent_flags};
            `SP_ADDR_NOC_FAULTS: read_mux = {2'h0, negative_overcurrent_flags};
            `SP_ADDR_OP_STATUS: read_mux = status_bits;
            `SP_ADDR_PIN_CFG_A: read_mux = pin_config_a_in;
            `SP_ADDR_PIN_CFG_B: read_mux = pin_config_b_in;
            `SP_ADDR_CHIP_CONTROL: read_mux = chip_control;
            `SP_ADDR_LOW_TRIM: read_mux = low_side_voltage_trim;
            `SP_ADDR_HIGH_TRIM: read_mux = high_side_voltage_trim;
            `SP_ADDR_CUR_TRIM: read_mux = current_set_trim;
            `SP_ADDR_SSFM: read_mux = spread_spectrum_cfg;
            default: read_mux = 8'h00;
        endcase
    end

    // framing: raising select always restarts the burst
    always_ff @(posedge sys_clk) begin
        if (rst || sel_n) begin
            state_q <= serial_port_pkg::ST_IDLE;
        end else begin
            case (state_q)
                serial_port_pkg::ST_IDLE: state_q <= serial_port_pkg::ST_ACTIVE;
                serial_port_pkg::ST_ACTIVE: begin
                    // mismatch on write: drop rest of burst
                    if (write_end(sclk_fall, bit_cnt_q, is_read) && !crc_ok_q) begin
                        state_q <= serial_port_pkg::ST_IGNORE;
                    end
                end
                serial_port_pkg::ST_IGNORE: state_q <= serial_port_pkg::ST_IGNORE;
                default: state_q <= serial_port_pkg::ST_IDLE;
            endcase
        end
    end

    logic active;
    assign active = (state_q == serial_port_pkg::ST_ACTIVE);

    // receive path: counts rising edges, captures bytes MSB first
    // the count saturates, so a long burst cannot wrap and commit twice
    always_ff @(posedge sys_clk) begin
        if (rst || !active) begin
            bit_cnt_q <= 6'd0;
            shift_in_q <= 8'h00;
            cmd_q <= 8'h00;
            data_q <= 8'h00;
        end else if (sclk_rise) begin
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= bit_cnt_q + 6'd1;
            end
            shift_in_q <= rx_byte;
            if (bit_cnt_q == `SP_CYC_CMD_END - 6'd1) begin
                cmd_q <= rx_byte;
            end
            if (bit_cnt_q == `SP_CYC_CRC_LATCH - 6'd1) begin
                data_q <= rx_byte;
            end
        end
    end

    // crc over command byte, then over received data (write) or returned data (read)
    always_ff @(posedge sys_clk) begin
        if (rst || !active) begin
            crc_q <= `SP_CRC_SEED;
            crc_hold_q <= 8'h00;
        end else if (sclk_rise && bit_cnt_q < `SP_CYC_CRC_LATCH) begin
            if (bit_cnt_q < `SP_CYC_CMD_END || !is_read) begin
                crc_q <= crc_step(crc_q, din_sync_q[1]);
                if (bit_cnt_q == `SP_CYC_CRC_LATCH - 6'd1) begin
                    crc_hold_q <= crc_step(crc_q, din_sync_q[1]);
                end
            end else begin
                crc_q <= crc_step(crc_q, tx_q[7]);
            end
        end else if (sclk_fall && is_read && bit_cnt_q == `SP_CYC_CRC_LATCH - 6'd1) begin
            // the last data bit goes out at this very edge, so fold it in here
            crc_hold_q <= crc_step(crc_q, tx_q[6]);
        end
    end

    // byte compare once the check byte has arrived
    always_ff @(posedge sys_clk) begin
        if (rst || !active) begin
            crc_ok_q <= 1'b0;
        end else if (sclk_rise && bit_cnt_q == `SP_CYC_COMMIT - 6'd1) begin
            // verdict at rise 24 so that it is ready for falling edge 24
            crc_ok_q <= (rx_byte == crc_hold_q);
        end
    end

    // transmit: data byte after command, then check byte; changes on falling edges
    // so that the master sees a settled bit at its next rising edge
    always_ff @(posedge sys_clk) begin
        if (rst || !active) begin
            tx_q <= 8'h00;
        end else if (sclk_fall && is_read) begin
            if (bit_cnt_q == `SP_CYC_CMD_END) begin
                tx_q <= read_mux;
            end else if (bit_cnt_q == `SP_CYC_CRC_LATCH) begin
                tx_q <= crc_hold_q;
            end else begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // output enable: from falling edge 8 to falling edge 24 of a read only
    always_ff @(posedge sys_clk) begin
        if (rst || !active) begin
            out_en_q <= 1'b0;
        end else if (sclk_fall && is_read) begin
            if (bit_cnt_q == `SP_CYC_CMD_END) begin
                out_en_q <= 1'b1;
            end else if (bit_cnt_q == `SP_CYC_COMMIT) begin
                out_en_q <= 1'b0;
            end
        end
    end

    assign serial_output = tx_q[7];
    assign serial_output_en = out_en_q & active & ~sel_n;

    assign commit_pulse = active && write_end(sclk_fall, bit_cnt_q, is_read) && crc_ok_q;
    assign comm_fault_set = active && write_end(sclk_fall, bit_cnt_q, is_read) && !crc_ok_q;

    logic wprot;
    assign wprot = chip_control[`SP_CTRL_WPROT_BIT];

    // chip control stays writable under protection, else protection could never be lifted
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chip_control <= `SP_RW_RESET;
        end else if (comm_fault_set) begin
            // set wins over any clear in the same cycle
            chip_control[`SP_CTRL_COMM_FAULT_BIT] <= 1'b1;
        end else if (commit_pulse && addr == `SP_ADDR_CHIP_CONTROL) begin
            chip_control <= data_q;
        end
    end

    // write protect blocks the three trims and spread_spectrum_cfg only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            low_side_voltage_trim <= `SP_RW_RESET;
            high_side_voltage_trim <= `SP_RW_RESET;
            current_set_trim <= `SP_RW_RESET;
            spread_spectrum_cfg <= `SP_RW_RESET;
        end else if (commit_pulse && !wprot) begin
            case (addr)
                `SP_ADDR_LOW_TRIM: low_side_voltage_trim <= data_q;
                `SP_ADDR_HIGH_TRIM: high_side_voltage_trim <= data_q;
                `SP_ADDR_CUR_TRIM: current_set_trim <= data_q;
                `SP_ADDR_SSFM: spread_spectrum_cfg <= data_q;
                default: low_side_voltage_trim <= low_side_voltage_trim;
            endcase
        end
    end

endmodule // crc_checked_serial_register_port

`default_nettype wire

// ===== tb/port_props.sv
`timescale 1ns/1ps
`default_nettype none
module port_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic serial_output_en,
    input wire logic [7:0] chip_control,
    input wire logic [7:0] low_side_voltage_trim,
    input wire logic [7:0] high_side_voltage_trim,
    input wire logic [7:0] current_set_trim,
    input wire logic [7:0] spread_spectrum_cfg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_hiz_deselect: assert property (port_select_n [*6] |-> !serial_output_en)
        else $error("output driven while deselected");
    chk_drive_framed: assert property (serial_output_en |-> !$past(port_select_n, 4))
        else $error("output driven outside a burst");
    chk_drive_after_cmd: assert property ($rose(serial_output_en) |-> !$past(port_select_n, 8))
        else $error("output driven before command byte");
    chk_ctrl_idle: assert property (port_select_n [*6] |=> $stable(chip_control))
        else $error("control changed between bursts");
    chk_trim_framed: assert property ($changed(low_side_voltage_trim) |-> !$past(port_select_n, 4))
        else $error("trim changed outside a burst");
    chk_cfg_framed: assert property ($changed({high_side_voltage_trim, current_set_trim}) |->
        !$past(port_select_n, 4)) else $error("setting changed outside a burst");
    chk_protect_trims: assert property (chip_control[0] && $past(chip_control[0]) |->
        $stable({low_side_voltage_trim, high_side_voltage_trim, current_set_trim, spread_spectrum_cfg}))
        else $error("protected trim changed");
    chk_reset_clears: assert property (disable iff (1'b0) rst |=> {chip_control, current_set_trim,
        low_side_voltage_trim, high_side_voltage_trim, spread_spectrum_cfg} == 40'h0)
        else $error("register not cleared by reset");
    cover property ($rose(serial_output_en));
    cover property ($rose(chip_control[3]));
    cover property ($rose(chip_control[0]));
endmodule // port_props
bind crc_checked_serial_register_port port_props port_props_i (.sys_clk, .rst, .port_select_n,
    .serial_output_en, .chip_control, .low_side_voltage_trim, .high_side_voltage_trim,
    .current_set_trim, .spread_spectrum_cfg);
`default_nettype wire

// ===== tb/serial_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
    input wire logic sys_clk,
    input wire logic sdo_line,
    output logic port_select_n,
    output logic serial_clock,
    output logic serial_input
);
    initial begin
        port_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_input = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // 24 clocks of 400 ns; rx keeps the last 16 bits seen
    task automatic burst(input logic [23:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        port_select_n = 1'b0;
        tick(4);
        for (int i = 23; i >= 0; i--) begin
            serial_input = tx[i];
            tick(4);
            rx = {rx[14:0], sdo_line};
            serial_clock = 1'b1;
            tick(4);
            serial_clock = 1'b0;
        end
        tick(4);
        port_select_n = 1'b1;
        // released line must not keep its last value
        serial_input = ~serial_input;
        tick(8);
    endtask
endmodule // serial_master_model
`default_nettype wire

// ===== tb/crc_checked_serial_register_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
module crc_checked_serial_register_port_tb;
    logic sys_clk, rst, port_select_n, serial_clock, serial_input, serial_output, serial_output_en;
    logic [7:0] chip_control, low_side_voltage_trim, high_side_voltage_trim, current_set_trim, spread_spectrum_cfg;
    logic [6:0] flt;
    logic [5:0] oc, noc;
    logic [2:0] st;
    logic [7:0] cfg_a, cfg_b;
    logic [15:0] alt [6] = '{16'h032A, 16'h0515, 16'h072A, 16'h0902, 16'h0B5A, 16'h0DA5};
    logic [15:0] rx;
    int n_fail, checks;
    wire logic [39:0] rw_regs = {chip_control, low_side_voltage_trim, high_side_voltage_trim,
        current_set_trim, spread_spectrum_cfg};
    wire logic sdo_line = serial_output_en ? serial_output : 1'b1;
    // rows are {command, data}: written data, or the data a read should return
    logic [15:0] rows [17] = '{16'h0E02, 16'h105A, 16'h12A5, 16'h1481, 16'h163C,
        16'h0355, 16'h052A, 16'h0715, 16'h0905, 16'h0BC3, 16'h0D3C,
        16'h0F02, 16'h115A, 16'h13A5, 16'h1581, 16'h173C, 16'h1900};
    crc_checked_serial_register_port crc_checked_serial_register_port_i (.sys_clk, .rst, .port_select_n,
        .serial_clock, .serial_input, .serial_output, .serial_output_en,
        .low_side_overvoltage(flt[6]), .high_side_overvoltage(flt[5]), .high_side_undervoltage(flt[4]),
        .driver_supply_undervoltage(flt[3]), .logic_supply_undervoltage(flt[2]), .reference_bad(flt[1]),
        .over_temperature(flt[0]), .overcurrent_flags(oc), .negative_overcurrent_flags(noc),
        .soft_start_done(st[2]), .max_current_reached(st[1]), .regulation_ok(st[0]),
        .pin_config_a_in(cfg_a), .pin_config_b_in(cfg_b), .chip_control, .low_side_voltage_trim,
        .high_side_voltage_trim, .current_set_trim, .spread_spectrum_cfg);
    serial_master_model serial_master_model_i (.sys_clk, .sdo_line, .port_select_n, .serial_clock,
        .serial_input);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] crc8(input logic [15:0] bits);
        logic [7:0] c;
        logic t0;
        c = 8'h41;
        for (int i = 15; i >= 0; i--) begin
            t0 = bits[i] ^ c[7];
            c = {c[6:2], c[1] ^ t0, c[0] ^ t0, t0};
        end
        return c;
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
    initial begin
        rst = 1'b1;
        flt = 7'h55;
        oc = 6'h2A;
        noc = 6'h15;
        st = 3'b101;
        cfg_a = 8'hC3;
        cfg_b = 8'h3C;
        n_fail = 0;
        checks = 0;
        serial_master_model_i.tick(20);
        rst = 1'b0;
        serial_master_model_i.tick(4);
        `CHK(rw_regs, 40'h0)
        $display("reset test done");
        foreach (rows[k]) begin
            serial_master_model_i.burst({rows[k], crc8(rows[k])}, rx);
            if (rows[k][8]) begin
                `CHK(rx, {rows[k][7:0], crc8(rows[k])})
            end
        end
        $display("row test done");
        // second set of monitor levels: every fault, overcurrent and status input is seen at both values, but not every pin config bit
        flt = 7'h2A;
        oc = 6'h15;
        noc = 6'h2A;
        st = 3'b010;
        cfg_a = 8'h5A;
        cfg_b = 8'hA5;
        foreach (alt[k]) begin
            serial_master_model_i.burst({alt[k], crc8(alt[k])}, rx);
            `CHK(rx, {alt[k][7:0], crc8(alt[k])})
        end
        $display("status level test done");
        // corrupted check byte must leave the trim alone and flag a fault
        serial_master_model_i.burst({16'h1011, ~crc8(16'h1011)}, rx);
        `CHK(low_side_voltage_trim, 8'h5A)
        `CHK(chip_control, 8'h0A)
        $display("bad check test done");
        serial_master_model_i.burst({16'h0E01, crc8(16'h0E01)}, rx);
        serial_master_model_i.burst({16'h1277, crc8(16'h1277)}, rx);
        `CHK({chip_control, high_side_voltage_trim}, 16'h01A5)
        $display("protect test done");
        rst = 1'b1;
        serial_master_model_i.tick(4);
        rst = 1'b0;
        serial_master_model_i.tick(1);
        `CHK(rw_regs, 40'h0)
        $display("second reset test done");
        finish_test();
    end
endmodule // crc_checked_serial_register_port_tb
`default_nettype wire
